// >>> rtl/spin_reverse_defs.svh
`ifndef SPIN_REVERSE_DEFS_SVH
`define SPIN_REVERSE_DEFS_SVH

// --------------------------------------------------------------------------
// register offsets, reset values and writable mask
// --------------------------------------------------------------------------
`define SPIN_DETECT_OFS      8'h80
`define REVERSE_DRIVE_OFS    8'h82
`define SPIN_DETECT_RST      32'h00000000
`define REVERSE_DRIVE_RST    32'h00000000
`define WRITABLE_MASK        32'h7fffffff

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define FLOAT_WAIT_LSB       9
`define STANDSTILL_LSB       6
`define SWITCHOVER_LSB       2
`define CURRENT_CAP_LSB      0
`define ACCEL_LIN_LSB        27
`define ACCEL_QUAD_LSB       23
`define BRAKE_LIMIT_LSB      20
`define BRAKE_KP_LSB         10
`define BRAKE_KI_LSB         0
`define BRAKE_LIMIT_RSVD     3'h7

`endif

// >>> rtl/spin_reverse_pkg.sv
package spin_reverse_pkg;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   // decoded settings: times in ms, voltages in mV, speed in 0.1 %,
   // currents in 0.1 mA, rates in 0.01 Hz/s (or Hz/s2)
   typedef struct packed {
      logic [15:0] floatWaitMs;
      logic [10:0] standstillMv;
      logic [9:0]  switchoverPermil;
      logic [15:0] reversalCapTenthMa;
      logic [19:0] accelLinearCenti;
      logic [19:0] accelQuadCenti;
      logic [15:0] brakeLimitTenthMa;
      logic        brakeLimitReserved;
      logic [9:0]  brakeKpRaw;
      logic [9:0]  brakeKiRaw;
   } settings_t;

   typedef struct packed {
      logic [31:0] spinDetect;
      logic [31:0] reverseDrive;
      logic [31:0] rdata;
      settings_t   decoded;
   } state_t;

endpackage

// >>> rtl/spin_detect_reverse_brake_cfg.sv
`include "spin_reverse_defs.svh"

// Functional notes
// [RULE1] float wait code 0h..Fh decodes to 10 ms .. 15 s, monotonic
// [RULE2] standstill back-emf threshold code 0h..7h gives 50..1500 mV
// [RULE3] reverse switchover speed code gives 2.5 % .. 100 % of max speed
// [RULE4] reversal current cap: 0.9375, 1.5625, 2.1875 or 3.125 A
// [RULE5] reverse drive register resets zero, bit 31 reads zero
// [RULE6] linear reversal acceleration code decodes 0.01 .. 10000 Hz/s
// [RULE7] quadratic reversal acceleration decodes from 0.0 Hz/s2 upward
// [RULE8] braking bus current limit 0.3125 .. 3.75 A, code 7h reserved
// [RULE9] braking proportional gain is field value over 2 to the 7th
// [RULE10] braking integral gain is field value over 2 to the 9th
// [RULE11] spin detect register resets zero, bit 31 read-only zero
// [RULE12] software avoids reserved codes; their effect is undefined
module spin_detect_reverse_brake_cfg
   import spin_reverse_pkg::*;
(
   // clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        clkEn,
   // register port
   input  wire reg_req_t    regReq,
   output logic [31:0]      regRdata,
   // decoded settings and raw register copies toward the motor control
   output settings_t        settings,
   output logic [31:0]      spinDetectRaw,
   output logic [31:0]      reverseDriveRaw
);

   // ------------------------------------------------------------------------
   // decode tables
   // ------------------------------------------------------------------------
   function automatic logic [15:0] waitMs(input logic [3:0] c);
      case (c)
         4'h0: begin
            waitMs = 16'd10;
         end
         4'h1: begin
            waitMs = 16'd50;
         end
         4'h2: begin
            waitMs = 16'd100;
         end
         4'h3: begin
            waitMs = 16'd200;
         end
         4'h4: begin
            waitMs = 16'd300;
         end
         4'h5: begin
            waitMs = 16'd400;
         end
         4'h6: begin
            waitMs = 16'd500;
         end
         4'h7: begin
            waitMs = 16'd750;
         end
         4'h8: begin
            waitMs = 16'd1000;
         end
         4'h9: begin
            waitMs = 16'd2000;
         end
         4'ha: begin
            waitMs = 16'd3000;
         end
         4'hb: begin
            waitMs = 16'd4000;
         end
         4'hc: begin
            waitMs = 16'd5000;
         end
         4'hd: begin
            waitMs = 16'd7500;
         end
         4'he: begin
            waitMs = 16'd10000;
         end
         default: begin
            waitMs = 16'd15000;
         end
      endcase
   endfunction

   function automatic logic [10:0] thrMv(input logic [2:0] c);
      case (c)
         3'h0: begin
            thrMv = 11'd50;
         end
         3'h1: begin
            thrMv = 11'd75;
         end
         3'h2: begin
            thrMv = 11'd100;
         end
         3'h3: begin
            thrMv = 11'd250;
         end
         3'h4: begin
            thrMv = 11'd500;
         end
         3'h5: begin
            thrMv = 11'd750;
         end
         3'h6: begin
            thrMv = 11'd1000;
         end
         default: begin
            thrMv = 11'd1500;
         end
      endcase
   endfunction

   function automatic logic [9:0] speedPermil(input logic [3:0] c);
      case (c)
         4'h0: begin
            speedPermil = 10'd25;
         end
         4'h1: begin
            speedPermil = 10'd50;
         end
         4'h2: begin
            speedPermil = 10'd75;
         end
         4'h3: begin
            speedPermil = 10'd100;
         end
         4'h4: begin
            speedPermil = 10'd125;
         end
         4'h5: begin
            speedPermil = 10'd150;
         end
         4'h6: begin
            speedPermil = 10'd200;
         end
         4'h7: begin
            speedPermil = 10'd250;
         end
         4'h8: begin
            speedPermil = 10'd300;
         end
         4'h9: begin
            speedPermil = 10'd400;
         end
         4'ha: begin
            speedPermil = 10'd500;
         end
         4'hb: begin
            speedPermil = 10'd600;
         end
         4'hc: begin
            speedPermil = 10'd700;
         end
         4'hd: begin
            speedPermil = 10'd800;
         end
         4'he: begin
            speedPermil = 10'd900;
         end
         default: begin
            speedPermil = 10'd1000;
         end
      endcase
   endfunction

   function automatic logic [15:0] capTenthMa(input logic [1:0] c);
      case (c)
         2'h0: begin
            capTenthMa = 16'd9375;
         end
         2'h1: begin
            capTenthMa = 16'd15625;
         end
         2'h2: begin
            capTenthMa = 16'd21875;
         end
         default: begin
            capTenthMa = 16'd31250;
         end
      endcase
   endfunction

   // shared by both acceleration fields; code 0h differs per field
   function automatic logic [19:0] accelCenti(input logic [3:0] c);
      case (c)
         4'h0: begin
            accelCenti = 20'd1;
         end
         4'h1: begin
            accelCenti = 20'd5;
         end
         4'h2: begin
            accelCenti = 20'd100;
         end
         4'h3: begin
            accelCenti = 20'd250;
         end
         4'h4: begin
            accelCenti = 20'd500;
         end
         4'h5: begin
            accelCenti = 20'd1000;
         end
         4'h6: begin
            accelCenti = 20'd2500;
         end
         4'h7: begin
            accelCenti = 20'd5000;
         end
         4'h8: begin
            accelCenti = 20'd7500;
         end
         4'h9: begin
            accelCenti = 20'd10000;
         end
         4'ha: begin
            accelCenti = 20'd25000;
         end
         4'hb: begin
            accelCenti = 20'd50000;
         end
         4'hc: begin
            accelCenti = 20'd75000;
         end
         4'hd: begin
            accelCenti = 20'd100000;
         end
         4'he: begin
            accelCenti = 20'd500000;
         end
         default: begin
            accelCenti = 20'd1000000;
         end
      endcase
   endfunction

   // reserved code 7h holds the 3.75 A ceiling rather than an open limit
   function automatic logic [15:0] brakeTenthMa(input logic [2:0] c);
      case (c)
         3'h0: begin
            brakeTenthMa = 16'd3125;
         end
         3'h1: begin
            brakeTenthMa = 16'd6250;
         end
         3'h2: begin
            brakeTenthMa = 16'd12500;
         end
         3'h3: begin
            brakeTenthMa = 16'd18750;
         end
         3'h4: begin
            brakeTenthMa = 16'd25000;
         end
         3'h5: begin
            brakeTenthMa = 16'd31250;
         end
         default: begin
            brakeTenthMa = 16'd37500;
         end
      endcase
   endfunction

   // ------------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------------
   state_t stateFf;
   state_t nxtState;
   logic   [31:0] nxtSpin;
   logic   [31:0] nxtRev;

   always_comb begin
      nxtState = stateFf;
      nxtSpin  = stateFf.spinDetect;
      nxtRev   = stateFf.reverseDrive;
      if (regReq.wr) begin
         if (regReq.addr == `SPIN_DETECT_OFS) begin
            nxtSpin = regReq.wdata & `WRITABLE_MASK; // see [RULE11]
         end
         if (regReq.addr == `REVERSE_DRIVE_OFS) begin
            nxtRev = regReq.wdata & `WRITABLE_MASK; // see [RULE5]
         end
      end
      nxtState.spinDetect   = nxtSpin;
      nxtState.reverseDrive = nxtRev;
      // read data stand only in the cycle after the strobe
      nxtState.rdata = 32'h00000000;
      if (regReq.rd) begin
         case (regReq.addr)
            `SPIN_DETECT_OFS:   nxtState.rdata = stateFf.spinDetect;
            `REVERSE_DRIVE_OFS: nxtState.rdata = stateFf.reverseDrive;
            default:            nxtState.rdata = 32'h00000000;
         endcase
      end
      // decode from the next value so settings track the raw copy exactly
      nxtState.decoded.floatWaitMs =
         waitMs(nxtSpin[`FLOAT_WAIT_LSB +: 4]); // see [RULE1]
      nxtState.decoded.standstillMv =
         thrMv(nxtSpin[`STANDSTILL_LSB +: 3]); // see [RULE2]
      nxtState.decoded.switchoverPermil =
         speedPermil(nxtSpin[`SWITCHOVER_LSB +: 4]); // see [RULE3]
      nxtState.decoded.reversalCapTenthMa =
         capTenthMa(nxtSpin[`CURRENT_CAP_LSB +: 2]); // see [RULE4]
      nxtState.decoded.accelLinearCenti =
         accelCenti(nxtRev[`ACCEL_LIN_LSB +: 4]); // see [RULE6]
      nxtState.decoded.accelQuadCenti =
         (nxtRev[`ACCEL_QUAD_LSB +: 4] == 4'h0) ? 20'd0 :
         accelCenti(nxtRev[`ACCEL_QUAD_LSB +: 4]); // see [RULE7]
      nxtState.decoded.brakeLimitTenthMa =
         brakeTenthMa(nxtRev[`BRAKE_LIMIT_LSB +: 3]); // see [RULE8]
      nxtState.decoded.brakeLimitReserved =
         (nxtRev[`BRAKE_LIMIT_LSB +: 3] == `BRAKE_LIMIT_RSVD); // see [RULE8]
      nxtState.decoded.brakeKpRaw =
         nxtRev[`BRAKE_KP_LSB +: 10]; // see [RULE9]
      nxtState.decoded.brakeKiRaw =
         nxtRev[`BRAKE_KI_LSB +: 10]; // see [RULE10]
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         stateFf.spinDetect   <= `SPIN_DETECT_RST;
         stateFf.reverseDrive <= `REVERSE_DRIVE_RST;
         stateFf.rdata        <= 32'h00000000;
         stateFf.decoded      <= '0;
         // zero codes decode to the lowest table entries
         stateFf.decoded.floatWaitMs        <= 16'd10;
         stateFf.decoded.standstillMv       <= 11'd50;
         stateFf.decoded.switchoverPermil   <= 10'd25;
         stateFf.decoded.reversalCapTenthMa <= 16'd9375;
         stateFf.decoded.accelLinearCenti   <= 20'd1;
         stateFf.decoded.brakeLimitTenthMa  <= 16'd3125;
      end else if (clkEn) begin
         stateFf <= nxtState;
      end
   end

   assign regRdata        = stateFf.rdata;
   assign settings        = stateFf.decoded;
   assign spinDetectRaw   = stateFf.spinDetect;
   assign reverseDriveRaw = stateFf.reverseDrive;

endmodule

// >>> bench/spin_reverse_chk.sv
`include "spin_reverse_defs.svh"
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module spin_reverse_chk
   import spin_reverse_pkg::*;
(
   // clock, reset and enable
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        clkEn,
   // register port
   input wire reg_req_t    regReq,
   input wire logic [31:0] regRdata,
   // results
   input wire settings_t   settings,
   input wire logic [31:0] spinDetectRaw,
   input wire logic [31:0] reverseDriveRaw
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   logic rev;
   logic spin;
   assign rev  = clkEn && regReq.addr == `REVERSE_DRIVE_OFS;
   assign spin = clkEn && regReq.addr == `SPIN_DETECT_OFS;
   property p_rd_idle; clkEn && !regReq.rd |=> regRdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read slot");
   property p_rd_rev; rev && regReq.rd |=> regRdata == $past(reverseDriveRaw);
   endproperty
   a_rd_rev: assert property (p_rd_rev)
      else $error("reverse read wrong");
   property p_rd_spin; spin && regReq.rd |=> regRdata == $past(spinDetectRaw);
   endproperty
   a_rd_spin: assert property (p_rd_spin)
      else $error("spin read wrong");
   property p_wr_rev; rev && regReq.wr |=>
      reverseDriveRaw == ($past(regReq.wdata) & `WRITABLE_MASK); endproperty
   a_wr_rev: assert property (p_wr_rev)
      else $error("reverse write wrong");
   // sampled reset too: the release edge still sees the old contents
   property p_hold_rev; !reset && !(rev && regReq.wr) |=>
      $stable(reverseDriveRaw); endproperty
   a_hold_rev: assert property (p_hold_rev)
      else $error("reverse changed without write");
   property p_rst; $fell(reset) |-> reverseDriveRaw == 32'h0
      && spinDetectRaw == 32'h0 && regRdata == 32'h0; endproperty
   a_rst: assert property (p_rst)
      else $error("not zero after reset");
   property p_bit31; !reverseDriveRaw[31] && !spinDetectRaw[31]; endproperty
   a_bit31: assert property (p_bit31)
      else $error("bit 31 set");
   property p_gain; settings.brakeKpRaw == reverseDriveRaw[19:10]
      && settings.brakeKiRaw == reverseDriveRaw[9:0]; endproperty
   a_gain: assert property (p_gain)
      else $error("gain fields wrong");
   property p_rsvd; settings.brakeLimitReserved
      == (reverseDriveRaw[22:20] == `BRAKE_LIMIT_RSVD); endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved flag wrong");
   property p_wait; spinDetectRaw[12:9] == 4'hf |->
      settings.floatWaitMs == 16'h3a98; endproperty
   a_wait: assert property (p_wait)
      else $error("longest wait wrong");
endmodule

// >>> bench/spin_detect_reverse_brake_cfg_test.sv
`include "spin_reverse_defs.svh"
// ----------------------------------------------------------------
// bench
// ----------------------------------------------------------------
module spin_detect_reverse_brake_cfg_test;
   timeunit 1ns;
   timeprecision 1ps;
   import spin_reverse_pkg::*;
   logic        core_clk = 1'b0;
   logic        reset    = 1'b1;
   logic        clkEn    = 1'b1;
   reg_req_t    regReq   = '0;
   logic [31:0] regRdata;
   logic [31:0] spinDetectRaw;
   logic [31:0] reverseDriveRaw;
   settings_t   settings;
   int          errorCnt       = 0;
   int          samplesChecked = 0;
   int waitT[16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 2000,
                     3000, 4000, 5000, 7500, 10000, 15000};
   int emfT[8]   = '{50, 75, 100, 250, 500, 750, 1000, 1500};
   int speedT[16] = '{25, 50, 75, 100, 125, 150, 200, 250, 300, 400, 500,
                      600, 700, 800, 900, 1000};
   int capT[4]   = '{9375, 15625, 21875, 31250};
   int accT[16]  = '{1, 5, 100, 250, 500, 1000, 2500, 5000, 7500, 10000,
                     25000, 50000, 75000, 100000, 500000, 1000000};
   int brkT[7]   = '{3125, 6250, 12500, 18750, 25000, 31250, 37500};
   spin_detect_reverse_brake_cfg i_dut (.core_clk, .reset, .clkEn, .regReq,
      .regRdata, .settings, .spinDetectRaw, .reverseDriveRaw);
   always #5 core_clk = ~core_clk;
   // driven on the edge, so each strobe stands one full cycle
   task automatic req(input logic [7:0] a, input logic [31:0] d,
                      input logic w, input logic r);
      @(posedge core_clk);
      regReq <= '{a, d, w, r};
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         errorCnt++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      req(a, 32'h0, 1'b0, 1'b1);
      req(8'h00, 32'h0, 1'b0, 1'b0);
      #1;
      cmp(regRdata, exp);
   endtask
   task automatic chk_spin(input int i);
      cmp(settings.floatWaitMs, waitT[i]);
      cmp(settings.standstillMv, emfT[i % 8]);
      cmp(settings.switchoverPermil, speedT[i]);
      cmp(settings.reversalCapTenthMa, capT[i % 4]);
   endtask
   task automatic chk_rev(input int i);
      cmp(settings.accelLinearCenti, accT[i]);
      cmp(settings.accelQuadCenti, (i > 0) ? accT[i] : 0);
      cmp(settings.brakeLimitTenthMa, brkT[i % 7]);
      cmp(settings.brakeLimitReserved, 1'b0);
      cmp(settings.brakeKpRaw, i * 67);
      cmp(settings.brakeKiRaw, i * 61);
   endtask
   // state straight out of the first reset
   task automatic t_reset;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      #1;
      chk_spin(0);
      chk_rev(0);
      cmp(regRdata, 32'h0);
      rd(`SPIN_DETECT_OFS, 32'h0);
      rd(`REVERSE_DRIVE_OFS, 32'h0);
   endtask
   // every code of every field except brake limit 7h and the gain fields, bit 31 always written as one
   task automatic t_codes;
      logic [31:0] d;
      logic [31:0] e;
      for (int i = 0; i < 16; i++) begin
         d = 32'h80000000 | i << 9 | i % 8 << 6 | i << 2 | i % 4;
         e = 32'h80000000 | i << 27 | i << 23 | i % 7 << 20 | i * 67 << 10;
         e = e | i * 61; // brake code never 7h
         req(`SPIN_DETECT_OFS, d, 1'b1, 1'b0);
         req(`REVERSE_DRIVE_OFS, e, 1'b1, 1'b0);
         rd(`SPIN_DETECT_OFS, d & 32'h7fffffff);
         chk_spin(i);
         rd(`REVERSE_DRIVE_OFS, e & 32'h7fffffff);
         chk_rev(i);
      end
   endtask
   // unmapped write, frozen write, then a second reset
   task automatic t_refused;
      req(`REVERSE_DRIVE_OFS, 32'h12345678, 1'b1, 1'b0);
      req(8'h84, 32'hffffffff, 1'b1, 1'b0);
      rd(8'h84, 32'h0);
      // the write is on the bus while the enable is low at the next edge
      req(`REVERSE_DRIVE_OFS, 32'h0, 1'b1, 1'b0);
      clkEn <= 1'b0;
      req(8'h00, 32'h0, 1'b0, 1'b0);
      clkEn <= 1'b1;
      rd(`REVERSE_DRIVE_OFS, 32'h12345678);
      @(posedge core_clk);
      reset <= 1'b1;
      @(posedge core_clk);
      reset <= 1'b0;
      #1;
      cmp(reverseDriveRaw, 32'h0);
      cmp(spinDetectRaw, 32'h0);
      cmp(regRdata, 32'h0);
      chk_rev(0);
      chk_spin(0);
   endtask
   task automatic tally_and_finish;
      if (errorCnt == 0 && samplesChecked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      t_reset;
      t_codes;
      t_refused;
      tally_and_finish;
   end
   // whole run is about 120 cycles
   initial begin
      #20000;
      errorCnt++;
      tally_and_finish;
   end
endmodule
bind spin_detect_reverse_brake_cfg spin_reverse_chk i_chk (.core_clk,
   .reset, .clkEn, .regReq, .regRdata, .settings, .spinDetectRaw,
   .reverseDriveRaw);
